// *** pgc_map.svh ***
`ifndef PGC_MAP_SVH
`define PGC_MAP_SVH

// register byte offsets
`define PGC_CTRL_OFS      8'h00
`define PGC_DUTY_OFS      8'h04
`define PGC_MDUTY_OFS     8'h08
`define PGC_PHASE_OFS     8'h0C
`define PGC_DT_OFS        8'h10
`define PGC_ISTAT_OFS     8'h14
`define PGC_IMASK_OFS     8'h18
`define PGC_STATE_OFS     8'h1C

// control register fields
`define PGC_FLTST_BIT     15
`define PGC_CLST_BIT      14
`define PGC_TRGST_BIT     13
`define PGC_FLTIE_BIT     12
`define PGC_CLIE_BIT      11
`define PGC_TRGIE_BIT     10
`define PGC_ITB_BIT       9
`define PGC_MASTER_DUTY_SEL_BIT      8
`define PGC_DTC_HI        7
`define PGC_DTC_LO        6
`define PGC_EXTERNAL_TIMEBASE_RESET_EN_BIT     1
`define PGC_IUE_BIT       0
// writable control bits: 12..6, 1, 0
`define PGC_CTRL_WMASK    16'h1FC3

// dead-time value field
`define PGC_DT_HI         13
`define PGC_DT_LO         2

// phase field
`define PGC_PH_WMASK      16'hFFFC

// reset values
`define PGC_ZERO16        16'h0000
`define PGC_ZERO32        32'h0000_0000
`define PGC_ZERO12        12'h000

// axi responses
`define PGC_RESP_OKAY     2'b00
`define PGC_RESP_SLVERR   2'b10

`endif

// *** pgc_pkg.sv ***
package pgc_pkg;
    typedef enum logic [1:0] {
        PGC_DT_POS,
        PGC_DT_NEG,
        PGC_DT_OFF,
        PGC_DT_RSVD
    } pgc_dtc_t;
endpackage

// *** pgc_timebase.sv ***
`timescale 1ns/1ps
`include "pgc_map.svh"
module pgc_timebase (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // period and restart
    input  wire logic [15:0] period,
    input  wire logic        restart,
    // count out
    output logic      [15:0] count,
    output logic             wrap
);
    logic [15:0] next_count;

    assign wrap       = (count >= period);
    assign next_count = (restart || wrap) ? `PGC_ZERO16
                                          : count + 16'h0001;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            count <= `PGC_ZERO16;
        end else begin
            count <= next_count;
        end
    end
endmodule // pgc_timebase

// *** pgc_gen.sv ***
`timescale 1ns/1ps
`include "pgc_map.svh"
// Notes on behaviour
// - current-limit interrupt enable lets a current-limit event raise an interrupt; clearing it clears its status flag.
// - trigger interrupt enable lets each trigger event raise an interrupt; clearing it clears its status flag.
// - independent time base select takes the period from the phase register, else the primary time base is used.
// - master duty select uses the shared master duty value, else the generator's own duty value.
// - dead-time control 00 applies positive dead time.
// - dead-time control 01 applies negative dead time.
// - dead-time control 10 disables dead time and 11 is reserved and must not be written.
// - control bits five to two are unimplemented and read zero.
// - with external reset enabled the current-limit input restarts the time base only in independent mode.
// - immediate update applies duty writes at once, otherwise at the time base wrap.
// - the generator duty value is 16 bits read/write and resets to zero.
// - dead time comes from an unsigned 12-bit dead-time value.
// - the master duty value is a shared 16-bit register.
module pgc_gen (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // events and primary time base
    input  wire logic        fault_event,
    input  wire logic        curlimit_event,
    input  wire logic        trigger_event,
    input  wire logic [15:0] primary_count,
    input  wire logic        primary_wrap,
    // generator outputs
    output logic             pwm_high,
    output logic             pwm_low,
    output logic             irq
);
    // registers
    logic [15:0] ctrl;
    logic [15:0] duty;
    logic [15:0] master_duty;
    logic [15:0] phase;
    logic [11:0] deadtime_value;
    logic [15:0] active_duty;
    logic [2:0]  irq_mask;
    logic [11:0] dt_cnt;
    logic        raw_q;
    logic        fault_irq_status;
    logic        curlimit_irq_status;
    logic        trigger_irq_status;

    // write channel latches: address and data taken in either order
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    // control fields
    wire fault_irq_enable           = ctrl[`PGC_FLTIE_BIT];
    wire curlimit_irq_enable        = ctrl[`PGC_CLIE_BIT];
    wire trigger_irq_enable         = ctrl[`PGC_TRGIE_BIT];
    wire independent_timebase_sel   = ctrl[`PGC_ITB_BIT];
    wire master_duty_sel            = ctrl[`PGC_MASTER_DUTY_SEL_BIT];
    wire external_timebase_reset_en = ctrl[`PGC_EXTERNAL_TIMEBASE_RESET_EN_BIT];
    wire immediate_update_en        = ctrl[`PGC_IUE_BIT];
    pgc_pkg::pgc_dtc_t deadtime_control;
    assign deadtime_control =
        pgc_pkg::pgc_dtc_t'(ctrl[`PGC_DTC_HI:`PGC_DTC_LO]);

    // bus decode
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    wire aw_fire  = s_axi_awvalid && s_axi_awready;
    wire w_fire   = s_axi_wvalid && s_axi_wready;
    wire have_aw  = aw_held || aw_fire;
    wire have_w   = w_held || w_fire;
    wire wr_go    = have_aw && have_w;
    wire [7:0]  wr_addr = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
    wire [3:0]  wr_strb = w_held ? w_strb : s_axi_wstrb;
    wire [15:0] bmask   = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
    wire wr_ctrl  = wr_go && (wr_addr == `PGC_CTRL_OFS);
    wire wr_duty  = wr_go && (wr_addr == `PGC_DUTY_OFS);
    wire wr_mduty = wr_go && (wr_addr == `PGC_MDUTY_OFS);
    wire wr_phase = wr_go && (wr_addr == `PGC_PHASE_OFS);
    wire wr_dt    = wr_go && (wr_addr == `PGC_DT_OFS);
    wire wr_istat = wr_go && (wr_addr == `PGC_ISTAT_OFS);
    wire wr_imask = wr_go && (wr_addr == `PGC_IMASK_OFS);
    wire wr_known = wr_ctrl || wr_duty || wr_mduty || wr_phase ||
                    wr_dt || wr_istat || wr_imask ||
                    (wr_addr == `PGC_STATE_OFS);
    wire [15:0] wd16 = wr_data[15:0];
    wire [15:0] next_ctrl_w = (ctrl & ~(bmask & `PGC_CTRL_WMASK)) |
                              (wd16 & bmask & `PGC_CTRL_WMASK);

    // time base
    logic [15:0] own_count;
    logic        own_wrap;
    wire tb_restart = external_timebase_reset_en &&
                      independent_timebase_sel && curlimit_event;
    pgc_timebase u_tb (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .period  (phase),
        .restart (tb_restart),
        .count   (own_count),
        .wrap    (own_wrap)
    );
    wire [15:0] tb_count = independent_timebase_sel ? own_count
                                                    : primary_count;
    wire        tb_wrap  = independent_timebase_sel ? own_wrap
                                                    : primary_wrap;

    // duty selection and update
    wire [15:0] own_duty_register = duty;
    wire [15:0] sel_duty = master_duty_sel ? master_duty
                                           : own_duty_register;
    wire [15:0] next_active = (immediate_update_en || tb_wrap) ? sel_duty
                                                               : active_duty;

    // events set flags only while enabled; set beats any clear
    wire fault_set = fault_event && fault_irq_enable;
    wire cl_set    = curlimit_event && curlimit_irq_enable;
    wire trg_set   = trigger_event && trigger_irq_enable;
    wire [15:0] clr_w1c = wr_istat ? wd16 & bmask : `PGC_ZERO16;
    wire next_fault = fault_set ||
        (fault_irq_status && fault_irq_enable &&
         !clr_w1c[`PGC_FLTST_BIT]);
    wire next_cl = cl_set ||
        (curlimit_irq_status && curlimit_irq_enable &&
         !clr_w1c[`PGC_CLST_BIT]);
    wire next_trg = trg_set ||
        (trigger_irq_status && trigger_irq_enable &&
         !clr_w1c[`PGC_TRGST_BIT]);
    wire [2:0] stat_vec = {fault_irq_status, curlimit_irq_status,
                           trigger_irq_status};
    assign irq = |(stat_vec & irq_mask);

    // dead-time unit
    wire raw_pwm  = (tb_count < active_duty);
    wire dt_off   = (deadtime_control == pgc_pkg::PGC_DT_OFF) ||
                    (deadtime_control == pgc_pkg::PGC_DT_RSVD);
    wire edge_seen = (raw_pwm != raw_q);
    wire dt_busy  = (dt_cnt != `PGC_ZERO12);
    // positive: both off during the gap; negative: both on
    wire gap_level = (deadtime_control == pgc_pkg::PGC_DT_NEG);
    wire [11:0] next_dt_cnt = dt_off ? `PGC_ZERO12 :
                              edge_seen ? deadtime_value :
                              dt_busy ? dt_cnt - 12'h001 : `PGC_ZERO12;
    wire in_gap = !dt_off && (edge_seen || dt_busy);
    wire next_hi = in_gap ? gap_level : raw_pwm;
    wire next_lo = in_gap ? gap_level : !raw_pwm;

    // read path
    wire [15:0] ctrl_rd = {stat_vec, ctrl[12:0]} & ~16'h003C;
    wire [31:0] rd_mux =
        (s_axi_araddr == `PGC_CTRL_OFS)  ? {16'h0000, ctrl_rd} :
        (s_axi_araddr == `PGC_DUTY_OFS)  ? {16'h0000, duty} :
        (s_axi_araddr == `PGC_MDUTY_OFS) ? {16'h0000, master_duty} :
        (s_axi_araddr == `PGC_PHASE_OFS) ? {16'h0000, phase} :
        (s_axi_araddr == `PGC_DT_OFS)    ? {18'h00000, deadtime_value,
                                            2'h0} :
        (s_axi_araddr == `PGC_ISTAT_OFS) ? {16'h0000, stat_vec,
                                            13'h0000} :
        (s_axi_araddr == `PGC_IMASK_OFS) ? {16'h0000, irq_mask,
                                            13'h0000} :
        (s_axi_araddr == `PGC_STATE_OFS) ? {active_duty, tb_count} :
                                           `PGC_ZERO32;
    wire rd_known = (s_axi_araddr <= `PGC_STATE_OFS) &&
                    (s_axi_araddr[1:0] == 2'h0);
    assign s_axi_arready = !s_axi_rvalid;
    wire ar_fire = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= `PGC_ZERO32;
            w_strb  <= 4'h0;
        end else begin
            aw_held <= have_aw && !wr_go;
            w_held  <= have_w && !wr_go;
            if (aw_fire) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PGC_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? `PGC_RESP_OKAY : `PGC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= `PGC_ZERO32;
            s_axi_rresp  <= `PGC_RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_known ? `PGC_RESP_OKAY : `PGC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl           <= `PGC_ZERO16;
            duty           <= `PGC_ZERO16;
            master_duty    <= `PGC_ZERO16;
            phase          <= `PGC_ZERO16;
            deadtime_value <= `PGC_ZERO12;
            irq_mask       <= 3'h0;
        end else begin
            if (wr_ctrl) ctrl <= next_ctrl_w;
            if (wr_duty) duty <= (duty & ~bmask) | (wd16 & bmask);
            if (wr_mduty) master_duty <= (master_duty & ~bmask) |
                                         (wd16 & bmask);
            if (wr_phase) phase <= (phase & ~(bmask & `PGC_PH_WMASK)) |
                                   (wd16 & bmask & `PGC_PH_WMASK);
            if (wr_dt && wr_strb[1] && wr_strb[0])
                deadtime_value <= wd16[`PGC_DT_HI:`PGC_DT_LO];
            if (wr_imask && wr_strb[1])
                irq_mask <= wd16[15:13];
        end
    end

    // generator state: duty update, status flags, dead-time outputs
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            active_duty         <= `PGC_ZERO16;
            fault_irq_status    <= 1'b0;
            curlimit_irq_status <= 1'b0;
            trigger_irq_status  <= 1'b0;
            dt_cnt              <= `PGC_ZERO12;
            raw_q               <= 1'b0;
            pwm_high            <= 1'b0;
            pwm_low             <= 1'b0;
        end else begin
            active_duty         <= next_active;
            fault_irq_status    <= next_fault;
            curlimit_irq_status <= next_cl;
            trigger_irq_status  <= next_trg;
            dt_cnt              <= next_dt_cnt;
            raw_q               <= raw_pwm;
            pwm_high            <= next_hi;
            pwm_low             <= next_lo;
        end
    end

    // assertions
    cl_flag_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !curlimit_irq_enable |=> !curlimit_irq_status)
        else $error("current-limit flag set while disabled");
    trg_flag_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (trigger_event && trigger_irq_enable) |=> trigger_irq_status)
        else $error("trigger flag not set");
    flt_flag_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (fault_event && fault_irq_enable) |=> fault_irq_status)
        else $error("fault flag not set");
    ctrl_unimpl_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ar_fire && s_axi_araddr == `PGC_CTRL_OFS)
        |=> s_axi_rdata[5:2] == 4'h0)
        else $error("unimplemented control bits read nonzero");
    imm_update_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        immediate_update_en |=> active_duty == $past(sel_duty))
        else $error("immediate duty update missed");
    hold_update_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!immediate_update_en && !tb_wrap)
        |=> $stable(active_duty))
        else $error("duty changed outside wrap");
    pos_gap_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (deadtime_control == pgc_pkg::PGC_DT_POS && edge_seen)
        |=> !pwm_high && !pwm_low)
        else $error("positive dead time not applied");
    neg_gap_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (deadtime_control == pgc_pkg::PGC_DT_NEG && edge_seen)
        |=> pwm_high && pwm_low)
        else $error("negative dead time not applied");
    dt_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (deadtime_control == pgc_pkg::PGC_DT_OFF)
        |=> pwm_high != pwm_low)
        else $error("outputs overlap with dead time off");
    tb_restart_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        tb_restart |=> own_count == 16'h0000)
        else $error("time base not restarted");
    irq_level_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cl_set && irq_mask[1] && !wr_imask) |=> irq)
        else $error("current-limit interrupt not raised");
    cov_cl_irq: cover property (@(posedge sys_clk) disable iff (!rstn)
        cl_set ##1 irq);
    cov_wrap_upd: cover property (@(posedge sys_clk) disable iff (!rstn)
        !immediate_update_en && tb_wrap && sel_duty != active_duty);
    cov_neg_dt: cover property (@(posedge sys_clk) disable iff (!rstn)
        gap_level && in_gap);
endmodule // pgc_gen

// *** pgc_power_stage.sv ***
`timescale 1ns/1ps
module pgc_power_stage (
    // clock and clear
    input  wire logic        sys_clk,
    input  wire logic        clr,
    // gate drives
    input  wire logic        pwm_high,
    input  wire logic        pwm_low,
    // observations
    output logic             node,
    output logic      [15:0] gap_cycles,
    output logic      [15:0] overlap_cycles
);
    // with both switches open the node floats, so it is shown drifting
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            node           <= 1'b0;
            gap_cycles     <= 16'h0000;
            overlap_cycles <= 16'h0000;
        end else begin
            if (pwm_high && !pwm_low)
                node <= 1'b1;
            else if (pwm_low && !pwm_high)
                node <= 1'b0;
            else
                node <= !node;
            if (!pwm_high && !pwm_low)
                gap_cycles <= gap_cycles + 16'h0001;
            // both on would short the supply rail
            if (pwm_high && pwm_low)
                overlap_cycles <= overlap_cycles + 16'h0001;
        end
    end
endmodule // pgc_power_stage

// *** tb.sv ***
`timescale 1ns/1ps
`include "pgc_map.svh"
module tb;
    logic        sys_clk, rstn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, clr, node;
    logic        pwm_high, pwm_low, irq, primary_wrap;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, rs;
    logic [2:0]  ev;
    logic [15:0] gap, ovl;
    int          miscompares, tests_run;

    pgc_gen dut (.sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .fault_event(ev[2]),
        .curlimit_event(ev[1]), .trigger_event(ev[0]),
        .primary_count(16'h1234), .primary_wrap(primary_wrap),
        .pwm_high(pwm_high), .pwm_low(pwm_low), .irq(irq));
    pgc_power_stage stage (.sys_clk(sys_clk), .clr(clr),
        .pwm_high(pwm_high), .pwm_low(pwm_low), .node(node),
        .gap_cycles(gap), .overlap_cycles(ovl));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = !sys_clk;
    end

    task automatic tally_and_finish();
        $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    // each channel is released at the rising edge that completes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic got;
        @(posedge sys_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        got = 1'b0;
        while (!got) begin
            @(posedge sys_clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid) begin
                got = 1'b1;
                rs  = bresp;
            end
        end
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        logic got;
        @(posedge sys_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        got = 1'b0;
        while (!got) begin
            @(posedge sys_clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid) begin
                got = 1'b1;
                rd  = rdata;
                rs  = rresp;
            end
        end
        rready <= 1'b0;
    endtask

    task automatic pulse(input int i);
        @(posedge sys_clk);
        ev[i] <= 1'b1;
        @(posedge sys_clk);
        ev[i] <= 1'b0;
    endtask

    task automatic chk_irq(input logic e);
        @(negedge sys_clk);
        chk({31'h0, irq}, {31'h0, e}, "irq");
    endtask

    initial begin
        #1000000;
        miscompares++;
        $display("[ERR] %0t watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        logic [15:0] en, st;
        rstn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0;
        rready = 0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
        wstrb = 4'hF; ev = 3'h0; primary_wrap = 0; clr = 1;
        miscompares = 0; tests_run = 0;
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        rdr(`PGC_CTRL_OFS);
        chk(rd, 32'h0, "control reset");
        rdr(`PGC_DUTY_OFS);
        chk(rd, 32'h0, "duty reset");
        wr(`PGC_CTRL_OFS, 32'h0000_1FBF);
        rdr(`PGC_CTRL_OFS);
        chk(rd, 32'h0000_1F83, "unimplemented bits");
        wr(`PGC_DUTY_OFS, 32'h0000_FFEF);
        rdr(`PGC_DUTY_OFS);
        chk(rd, 32'h0000_FFEF, "duty max");
        wr(`PGC_DUTY_OFS, 32'h0000_0008);
        rdr(`PGC_DUTY_OFS);
        chk(rd, 32'h0000_0008, "duty min");
        rdr(8'h20);
        chk({30'h0, rs}, {30'h0, `PGC_RESP_SLVERR}, "unmapped read");
        chk(rd, 32'h0, "unmapped read data");
        wr(8'h24, 32'h0000_FFFF);
        chk({30'h0, rs}, {30'h0, `PGC_RESP_SLVERR}, "unmapped write");
        // fault, current-limit and trigger share one pattern
        for (int i = 0; i < 3; i++) begin
            en = 16'h0001 << (10 + i);
            st = 16'h0001 << (13 + i);
            wr(`PGC_CTRL_OFS, 32'h0000_0080);
            pulse(i);
            rdr(`PGC_CTRL_OFS);
            chk(rd, 32'h0000_0080, "flag while disabled");
            wr(`PGC_CTRL_OFS, {16'h0, en | 16'h0080});
            pulse(i);
            repeat (3) @(posedge sys_clk);
            rdr(`PGC_CTRL_OFS);
            chk(rd, {16'h0, st | en | 16'h0080}, "sticky flag");
            chk_irq(1'b0);
            wr(`PGC_IMASK_OFS, {16'h0, st});
            chk_irq(1'b1);
            wr(`PGC_ISTAT_OFS, {16'h0, st});
            rdr(`PGC_ISTAT_OFS);
            chk(rd, 32'h0, "status cleared");
            chk_irq(1'b0);
            pulse(i);
            chk_irq(1'b1);
            wr(`PGC_CTRL_OFS, 32'h0000_0080);
            rdr(`PGC_CTRL_OFS);
            chk(rd, 32'h0000_0080, "clear by enable");
            chk_irq(1'b0);
            wr(`PGC_IMASK_OFS, 32'h0);
        end
        wr(`PGC_DUTY_OFS, 32'h0000_1000);
        rdr(`PGC_STATE_OFS);
        chk(rd, 32'h0000_1234, "held duty");
        @(posedge sys_clk);
        primary_wrap <= 1'b1;
        @(posedge sys_clk);
        primary_wrap <= 1'b0;
        rdr(`PGC_STATE_OFS);
        chk(rd, 32'h1000_1234, "duty at wrap");
        wr(`PGC_CTRL_OFS, 32'h0000_0081);
        wr(`PGC_DUTY_OFS, 32'h0000_2000);
        rdr(`PGC_STATE_OFS);
        chk({16'h0, rd[31:16]}, 32'h2000, "immediate duty");
        wr(`PGC_MDUTY_OFS, 32'h0000_3000);
        wr(`PGC_CTRL_OFS, 32'h0000_0181);
        rdr(`PGC_STATE_OFS);
        chk({16'h0, rd[31:16]}, 32'h3000, "master duty");
        wr(`PGC_PHASE_OFS, 32'h0000_0040);
        wr(`PGC_CTRL_OFS, 32'h0000_0281);
        repeat (2) begin
            rdr(`PGC_STATE_OFS);
            chk({31'h0, rd[15:0] <= 16'h0040}, 32'h1, "own period");
        end
        wr(`PGC_PHASE_OFS, 32'h0000_FFFC);
        for (int x = 1; x >= 0; x--) begin
            wr(`PGC_CTRL_OFS, {16'h0, 16'h0281 | (x[0] << 1)});
            repeat (200) @(posedge sys_clk);
            pulse(1);
            rdr(`PGC_STATE_OFS);
            // a restart leaves only the read latency on the count
            chk({31'h0, rd[15:0] < 16'h0010}, {31'h0, x[0]}, "restart");
        end
        wr(`PGC_DT_OFS, 32'h0000_FFFF);
        rdr(`PGC_DT_OFS);
        chk(rd, 32'h0000_3FFC, "deadtime field");
        wr(`PGC_DT_OFS, 32'h0000_000C);
        wr(`PGC_PHASE_OFS, 32'h0000_0040);
        wr(`PGC_DUTY_OFS, 32'h0000_0020);
        // code 11 is never written: software keeps it reserved
        for (int d = 0; d < 3; d++) begin
            wr(`PGC_CTRL_OFS, {16'h0, 16'h0201 | (d[1:0] << 6)});
            repeat (10) @(posedge sys_clk);
            clr <= 1'b0;
            repeat (300) @(posedge sys_clk);
            @(negedge sys_clk);
            chk({30'h0, gap != 0, ovl != 0},
                {30'h0, d == 0, d == 1}, "dead time");
            @(posedge sys_clk);
            clr <= 1'b1;
        end
        tally_and_finish();
    end
endmodule // tb
